// ===== cell_balance_expiry_params.svh
// Constants for the cell balancing expiry timer bank (cells 10 to 13).
// Assumes a 125 MHz core clock and a register port supplied by the serial link logic.
`ifndef CELL_BALANCE_EXPIRY_PARAMS_SVH
`define CELL_BALANCE_EXPIRY_PARAMS_SVH

`define CBE_ADDR_W          8
`define CBE_DATA_W          16
`define CBE_FIELD_W         10
`define CBE_NUM_CELLS       4
`define CBE_OFS_CELL10      8'h79
`define CBE_OFS_CELL11      8'h7a
`define CBE_OFS_CELL12      8'h7b
`define CBE_OFS_CELL13      8'h7c
`define CBE_FIELD_RESET     10'h000
`define CBE_FIELD_FOREVER   10'h3ff
`define CBE_CLK_HZ          125000000
`define CBE_SECOND_CYCLES   (`CBE_CLK_HZ * 1)
`define CBE_SEC_PER_MIN     60
`define CBE_SEC_PER_HOUR    3600
`define CBE_MODE_W          3

`endif

// ===== cell_balance_expiry_pkg.sv
// Types for the cell balancing expiry timer bank.
// Assumes the params header is included by every user as well.
package cell_balance_expiry_pkg;

  // Balancing mode code; top bit set means an automated mode.
  typedef logic [2:0] balance_mode_type;

  // Unit of one expiry count.
  typedef enum logic [2:0] {
    unit_second = 3'b001,
    unit_minute = 3'b010,
    unit_hour   = 3'b100
  } time_unit_type;

endpackage

// ===== expiry_tick_gen.sv
// Time base: one-cycle ticks for seconds, minutes and hours from the core clock.
// Assumes one 125 MHz clock; tick lengths are parameters so simulation can shorten them.
`timescale 1ns/1ps
`include "cell_balance_expiry_params.svh"

module expiry_tick_gen #(
  parameter int unsigned SECOND_CYCLES = `CBE_SECOND_CYCLES,
  parameter int unsigned SEC_PER_MIN   = `CBE_SEC_PER_MIN,
  parameter int unsigned SEC_PER_HOUR  = `CBE_SEC_PER_HOUR
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Ticks
  output logic      sec_tick,
  output logic      min_tick,
  output logic      hour_tick
);

  logic [26:0] cyc_q;
  logic [5:0]  sec_q;
  logic [11:0] hsec_q;
  wire         sec_end  = (cyc_q == 27'(SECOND_CYCLES - 1));
  wire         min_end  = sec_end && (sec_q == 6'(SEC_PER_MIN - 1));
  wire         hour_end = sec_end && (hsec_q == 12'(SEC_PER_HOUR - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q     <= 27'h0000000;
      sec_q     <= 6'h00;
      hsec_q    <= 12'h000;
      sec_tick  <= 1'b0;
      min_tick  <= 1'b0;
      hour_tick <= 1'b0;
    end else begin
      cyc_q     <= sec_end ? 27'h0000000 : cyc_q + 27'h0000001;
      sec_q     <= min_end ? 6'h00 : (sec_end ? sec_q + 6'h01 : sec_q);
      hsec_q    <= hour_end ? 12'h000 : (sec_end ? hsec_q + 12'h001 : hsec_q);
      sec_tick  <= sec_end;
      min_tick  <= min_end;
      hour_tick <= hour_end;
    end
  end

endmodule // expiry_tick_gen

// ===== cell_balance_expiry_timers.sv
// Expiry registers and per-cell balancing timers for cells 10 to 13.
// Assumes a synchronous register port from the serial link decoder and a mode code from the mode register.
`timescale 1ns/1ps
`include "cell_balance_expiry_params.svh"

module cell_balance_expiry_timers #(
  parameter int unsigned SECOND_CYCLES = `CBE_SECOND_CYCLES,
  parameter int unsigned SEC_PER_MIN   = `CBE_SEC_PER_MIN,
  parameter int unsigned SEC_PER_HOUR  = `CBE_SEC_PER_HOUR,
  // Individual automated mode codes; plain defaults, adjust to the mode register.
  parameter logic [2:0]  MODE_IND_SEC  = 3'h4,
  parameter logic [2:0]  MODE_IND_MIN  = 3'h5,
  parameter logic [2:0]  MODE_IND_HOUR = 3'h6
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // Register port
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [`CBE_ADDR_W-1:0]        reg_addr,
  input  wire logic [`CBE_DATA_W-1:0]        reg_wdata,
  output logic      [`CBE_DATA_W-1:0]        reg_rdata,
  output logic                               reg_hit,
  output logic                               reg_wr_refused,
  // Balancing control
  input  wire cell_balance_expiry_pkg::balance_mode_type balance_mode_select,
  input  wire logic [`CBE_NUM_CELLS-1:0]     balance_request,
  output logic      [`CBE_NUM_CELLS-1:0]     balance_switch_on
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic [`CBE_NUM_CELLS-1:0] sel_of(input logic [`CBE_ADDR_W-1:0] a);
    sel_of = {a == `CBE_OFS_CELL13, a == `CBE_OFS_CELL12, a == `CBE_OFS_CELL11, a == `CBE_OFS_CELL10};
  endfunction

  wire [`CBE_NUM_CELLS-1:0] sel      = sel_of(reg_addr);
  wire                      automated = balance_mode_select[2];
  wire                      wr_block = automated;
  wire                      ind_mode = (balance_mode_select == MODE_IND_SEC) ||
                                       (balance_mode_select == MODE_IND_MIN) ||
                                       (balance_mode_select == MODE_IND_HOUR);

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  logic sec_tick;
  logic min_tick;
  logic hour_tick;

  expiry_tick_gen #(
    .SECOND_CYCLES (SECOND_CYCLES),
    .SEC_PER_MIN   (SEC_PER_MIN),
    .SEC_PER_HOUR  (SEC_PER_HOUR)
  ) u_ticks (
    .clk       (clk),
    .arst_n    (arst_n),
    .sec_tick  (sec_tick),
    .min_tick  (min_tick),
    .hour_tick (hour_tick)
  );

  cell_balance_expiry_pkg::time_unit_type unit;
  assign unit = (balance_mode_select == MODE_IND_HOUR) ? cell_balance_expiry_pkg::unit_hour :
                (balance_mode_select == MODE_IND_MIN)  ? cell_balance_expiry_pkg::unit_minute :
                                                         cell_balance_expiry_pkg::unit_second;
  logic unit_tick;
  always_comb begin
    unique case (unit)
      cell_balance_expiry_pkg::unit_second: unit_tick = sec_tick;
      cell_balance_expiry_pkg::unit_minute: unit_tick = min_tick;
      cell_balance_expiry_pkg::unit_hour:   unit_tick = hour_tick;
      default:                              unit_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Per-cell registers and timers
  // ------------------------------------------------------------
  logic [`CBE_FIELD_W-1:0] field_q [`CBE_NUM_CELLS];
  logic [`CBE_FIELD_W-1:0] count_q [`CBE_NUM_CELLS];
  logic [`CBE_NUM_CELLS-1:0] sw_d;

  genvar i;
  generate
    for (i = 0; i < `CBE_NUM_CELLS; i++) begin : g_cell
      wire wr_ok   = reg_wr && sel[i] && !wr_block;
      wire forever_code = (field_q[i] == `CBE_FIELD_FOREVER);
      wire expired = (field_q[i] == `CBE_FIELD_RESET) ||
                     (!forever_code && count_q[i] >= field_q[i]);
      wire running = ind_mode && balance_request[i];

      assign sw_d[i] = running && !expired;

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          field_q[i] <= `CBE_FIELD_RESET;
          count_q[i] <= 10'h000;
        end else begin
          if (wr_ok) begin
            field_q[i] <= reg_wdata[`CBE_FIELD_W-1:0];
          end
          if (!running) begin
            count_q[i] <= 10'h000;
          end else if (unit_tick && !expired && !forever_code) begin
            count_q[i] <= count_q[i] + 10'h001;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [`CBE_FIELD_W-1:0] rd_field;
  always_comb begin
    rd_field = 10'h000;
    for (int k = 0; k < `CBE_NUM_CELLS; k++) begin
      if (sel[k]) begin
        rd_field = field_q[k];
      end
    end
  end

  // Reads return zero for unmapped offsets so the link sees a defined value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata         <= 16'h0000;
      reg_hit           <= 1'b0;
      reg_wr_refused    <= 1'b0;
      balance_switch_on <= 4'h0;
    end else begin
      reg_rdata         <= reg_rd ? {6'h00, rd_field} : 16'h0000;
      reg_hit           <= (reg_rd || reg_wr) && (|sel);
      reg_wr_refused    <= reg_wr && (|sel) && wr_block;
      balance_switch_on <= sw_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_refused_write_kept;
    @(posedge clk) disable iff (!arst_n)
      (reg_wr && sel[0] && wr_block) |=> (field_q[0] == $past(field_q[0]));
  endproperty
  a_refused_write_kept: assert property (p_refused_write_kept) else $error("refused write changed field");

  property p_write_readback;
    @(posedge clk) disable iff (!arst_n)
      (reg_wr && sel[1] && !wr_block) |=> (field_q[1] == $past(reg_wdata[9:0]));
  endproperty
  a_write_readback: assert property (p_write_readback) else $error("write not stored");

  property p_read_upper_zero;
    @(posedge clk) disable iff (!arst_n) reg_rdata[15:10] == 6'h00;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper bits not zero");

  property p_zero_disables;
    @(posedge clk) disable iff (!arst_n) (field_q[2] == 10'h000) |=> !balance_switch_on[2];
  endproperty
  a_zero_disables: assert property (p_zero_disables) else $error("zero field balanced");

  property p_forever_on;
    @(posedge clk) disable iff (!arst_n)
      (field_q[3] == 10'h3ff && ind_mode && balance_request[3]) |=> balance_switch_on[3];
  endproperty
  a_forever_on: assert property (p_forever_on) else $error("forever code expired");

  property p_other_mode_off;
    @(posedge clk) disable iff (!arst_n) !ind_mode |=> (balance_switch_on == 4'h0);
  endproperty
  a_other_mode_off: assert property (p_other_mode_off) else $error("switch on outside ind mode");

  property p_expiry_opens;
    @(posedge clk) disable iff (!arst_n)
      (field_q[0] != 10'h3ff && count_q[0] >= field_q[0]) |=> !balance_switch_on[0];
  endproperty
  a_expiry_opens: assert property (p_expiry_opens) else $error("switch past expiry");

  property p_read_decode;
    @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == 8'h7c) |=> (reg_rdata[9:0] == $past(field_q[3]));
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("bad read at cell 13");

  property p_unit_pick;
    @(posedge clk) disable iff (!arst_n)
      (balance_mode_select == MODE_IND_HOUR) |-> (unit_tick == hour_tick);
  endproperty
  a_unit_pick: assert property (p_unit_pick) else $error("wrong time unit");

  property p_refused_flag;
    @(posedge clk) disable iff (!arst_n)
      (reg_wr && (|sel) && wr_block) |=> reg_wr_refused;
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("refused write not flagged");

  // The link must never latch stale data, so read data stays zero between reads.
  property p_idle_read_zero;
    @(posedge clk) disable iff (!arst_n) !reg_rd |=> (reg_rdata == 16'h0000);
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data without a read");

  c_refused: cover property (@(posedge clk) disable iff (!arst_n) reg_wr_refused);
  c_expire:  cover property (@(posedge clk) disable iff (!arst_n) balance_switch_on[0] ##1 !balance_switch_on[0]);
  c_write:   cover property (@(posedge clk) disable iff (!arst_n) reg_wr && |sel && !wr_block);
  c_forever: cover property (@(posedge clk) disable iff (!arst_n)
               balance_switch_on[2] && (field_q[2] == `CBE_FIELD_FOREVER));
  c_hour:    cover property (@(posedge clk) disable iff (!arst_n) (balance_mode_select == MODE_IND_HOUR) && unit_tick);

endmodule // cell_balance_expiry_timers

// ===== tb_cell_balance_expiry_timers.sv
// Self-checking testbench for the cell balancing expiry timer bank, cells 10 to 13.
// Assumes the design files are compiled first; unit ticks are shortened by parameters.
`timescale 1ns/1ps
`include "cell_balance_expiry_params.svh"

module tb_cell_balance_expiry_timers;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        clk                 = 1'b0;
  logic        arst_n              = 1'b0;
  logic        reg_wr              = 1'b0;
  logic        reg_rd              = 1'b0;
  logic [7:0]  reg_addr            = 8'h00;
  logic [15:0] reg_wdata           = 16'h0000;
  logic [2:0]  balance_mode_select = 3'h0;
  logic [3:0]  balance_request     = 4'h0;
  logic [15:0] reg_rdata;
  logic        reg_hit;
  logic        reg_wr_refused;
  logic [3:0]  balance_switch_on;
  logic [15:0] rd_seen;
  logic        hit_seen;
  logic        ref_seen;
  logic [9:0]  vals [4]            = '{10'h2a5, 10'h15a, 10'h3ff, 10'h001};
  int          err_count           = 0;
  int          comparisons         = 0;

  // One second is ten cycles here, so a minute is 30 cycles and an hour 50.
  always #4 clk = ~clk;

  cell_balance_expiry_timers #(
    .SECOND_CYCLES (10),
    .SEC_PER_MIN   (3),
    .SEC_PER_HOUR  (5)
  ) dut (
    .clk                 (clk),
    .arst_n              (arst_n),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .reg_hit             (reg_hit),
    .reg_wr_refused      (reg_wr_refused),
    .balance_mode_select (balance_mode_select),
    .balance_request     (balance_request),
    .balance_switch_on   (balance_switch_on)
  );

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One strobe cycle; the answer stands during the following cycle.
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_seen = reg_rdata;
    hit_seen = reg_hit;
    ref_seen = reg_wr_refused;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic reset_values;
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 8'h79 + 8'(i), 16'h0000);
      check(rd_seen, 16'h0000);
      check({15'h0, hit_seen}, 16'h0001);
    end
  endtask

  // Upper bits are written as ones to prove they never stick.
  task automatic write_readback;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, 8'h79 + 8'(i), {6'h3f, vals[i]});
    end
    access(1'b1, 8'h78, 16'hffff);
    access(1'b1, 8'h7d, 16'hffff);
    access(1'b0, 8'h7d, 16'h0000);
    check(rd_seen, 16'h0000);
    check({15'h0, hit_seen}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 8'h79 + 8'(i), 16'h0000);
      check(rd_seen, {6'h00, vals[i]});
    end
  endtask

  // A reset in mid-run must clear fields that hold written values.
  task automatic mid_reset;
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    reset_values();
  endtask

  task automatic refused_writes;
    logic [9:0] held;
    held = vals[1];
    for (int m = 0; m < 8; m++) begin
      balance_mode_select = 3'(m);
      access(1'b1, 8'h7a, {6'h00, 10'h100 + 10'(m)});
      check({15'h0, ref_seen}, {15'h0, m[2]});
      held = m[2] ? held : 10'h100 + 10'(m);
      balance_mode_select = 3'h0;
      access(1'b0, 8'h7a, 16'h0000);
      check(rd_seen, {6'h00, held});
    end
  endtask

  // Cell 10 runs two units, 11 is off, 12 runs forever, 13 runs far past the window.
  task automatic timer_modes;
    int unit [3] = '{10, 30, 50};
    int n;
    access(1'b1, 8'h79, 16'h0002);
    access(1'b1, 8'h7a, 16'h0000);
    access(1'b1, 8'h7b, 16'h03ff);
    access(1'b1, 8'h7c, 16'h03fe);
    for (int k = 0; k < 3; k++) begin
      balance_mode_select = 3'h4 + 3'(k);
      balance_request = 4'hf;
      repeat (3) @(posedge clk);
      #1;
      check({12'h0, balance_switch_on}, 16'h000d);
      n = 3;
      while (balance_switch_on[0] === 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n == 200) begin
        err_count++;
        complete_run();
      end
      check({15'h0, n >= unit[k] && n <= 2 * unit[k] + 3}, 16'h0001);
      check({13'h0, balance_switch_on[3:1]}, 16'h0006);
      balance_request = 4'h0;
      balance_mode_select = 3'h0;
      repeat (2) @(posedge clk);
      #1;
      check({12'h0, balance_switch_on}, 16'h0000);
    end
  endtask

  task automatic other_modes;
    logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    for (int i = 0; i < 5; i++) begin
      balance_mode_select = modes[i];
      balance_request = 4'hf;
      repeat (4) @(posedge clk);
      #1;
      check({12'h0, balance_switch_on}, 16'h0000);
      balance_request = 4'h0;
    end
    balance_mode_select = 3'h0;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    reset_values();
    write_readback();
    mid_reset();
    refused_writes();
    timer_modes();
    other_modes();
    complete_run();
  end
endmodule // tb_cell_balance_expiry_timers
